// ==== alr_pkg.sv ====
/*
 * Constants, offsets and helpers for the application-layer state and
 * indicator register group. Assumes one 40 MHz core clock everywhere.
 */
`default_nettype none

package alr_pkg;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses, words on even addresses)
    // ---------------------------------------------------------------
    localparam logic [15:0] ADDR_STATE_REQUEST = 16'h0120;
    localparam logic [15:0] ADDR_STATE_ACTUAL = 16'h0130;
    localparam logic [15:0] ADDR_STATUS_CODE = 16'h0134;
    localparam logic [15:0] ADDR_RUN_OVERRIDE = 16'h0138;
    localparam logic [15:0] ADDR_ERR_OVERRIDE = 16'h0139;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int BIT_ERR_IND = 4;
    localparam int BIT_DEV_ID = 5;
    localparam int BIT_OVR_EN = 4;
    localparam logic [5:0] STATE_REQUEST_RESET = 6'h01;
    localparam logic [5:0] STATE_ACTUAL_RESET = 6'h01;
    localparam logic [15:0] STATUS_CODE_RESET = 16'h0000;
    localparam logic [4:0] OVERRIDE_RESET = 5'h00;

    // ---------------------------------------------------------------
    // State codes and indicator codes
    // ---------------------------------------------------------------
    localparam logic [3:0] ST_INIT = 4'h1;
    localparam logic [3:0] ST_PREOPERATIONAL_STATE = 4'h2;
    localparam logic [3:0] ST_BOOT = 4'h3;
    localparam logic [3:0] ST_SAFE_OPERATIONAL_STATE = 4'h4;
    localparam logic [3:0] ST_OP = 4'h8;
    localparam logic [3:0] IND_OFF = 4'h0;
    localparam logic [3:0] IND_FLASH1 = 4'h1;
    localparam logic [3:0] IND_BLINK = 4'hd;
    localparam logic [3:0] IND_FLICKER = 4'he;
    localparam logic [3:0] IND_ON = 4'hf;

    // ---------------------------------------------------------------
    // Timing: one pattern tick, patterns counted in ticks
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_MS = 50;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [6:0] FLASH_PERIOD = 7'h08;
    localparam logic [6:0] FLASH_PAUSE = 7'h14;
    localparam logic [6:0] BLINK_PERIOD = 7'h08;
    localparam logic [6:0] FLICKER_PERIOD = 7'h02;
    localparam logic [2:0] ON_PHASES = 3'h4;

    function automatic logic state_valid(input logic [3:0] s);
        return (s == ST_INIT) || (s == ST_PREOPERATIONAL_STATE) || (s == ST_BOOT) ||
               (s == ST_SAFE_OPERATIONAL_STATE) || (s == ST_OP);
    endfunction

    function automatic logic [3:0] run_code_of_state(input logic [3:0] s);
        case (s)
            ST_SAFE_OPERATIONAL_STATE: return IND_FLASH1;
            ST_PREOPERATIONAL_STATE: return IND_BLINK;
            ST_BOOT: return IND_FLICKER;
            ST_OP: return IND_ON;
            default: return IND_OFF;
        endcase
    endfunction

endpackage

`default_nettype wire

// ==== alr_tick_div.sv ====
/*
 * Divider making a one-cycle tick every DIV core clocks.
 * Assumes the same clock and reset as the register group.
 */
`timescale 1ns/1ps
`default_nettype none

module alr_tick_div
    import alr_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

    if (DIV < 2) begin : g_check
        $error("alr_tick_div: DIV must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } alr_div_t;

    alr_div_t r;
    alr_div_t next_r;

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.cnt == CW'(DIV - 1)) begin
            next_r.cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;

endmodule // alr_tick_div

`default_nettype wire

// ==== alr_ind_pattern.sv ====
/*
 * Indicator pattern generator: turns a 4-bit code into a lamp level.
 * Assumes a one-cycle tick enable from a divider on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module alr_ind_pattern
    import alr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic [3:0] code,
    output logic level
);

    typedef struct packed {
        logic [6:0] phase;
        logic level;
    } alr_pat_t;

    alr_pat_t r;
    alr_pat_t next_r;

    always_comb begin
        logic [6:0] len;
        logic [6:0] ph;
        len = 7'h01;
        ph = r.phase;
        next_r = r;
        case (code)
            IND_OFF, IND_ON: len = 7'h01;
            IND_BLINK: len = BLINK_PERIOD;
            IND_FLICKER: len = FLICKER_PERIOD;
            default: len = 7'({3'h0, code} * FLASH_PERIOD) + FLASH_PAUSE;
        endcase
        // Wrap also catches a phase left over from a longer code
        if (tick) begin
            ph = ph + 7'h01;
        end
        if (ph >= len) begin
            ph = 7'h00;
        end
        next_r.phase = ph;
        case (code)
            IND_OFF: next_r.level = 1'b0;
            IND_ON: next_r.level = 1'b1;
            IND_BLINK: next_r.level = (ph < {4'h0, ON_PHASES});
            IND_FLICKER: next_r.level = ~ph[0];
            default: begin
                next_r.level = (ph < 7'({3'h0, code} * FLASH_PERIOD)) &&
                               (ph[2:0] < ON_PHASES);
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;

endmodule // alr_ind_pattern

`default_nettype wire

// ==== alr_state_regs.sv ====
/*
 * Application-layer state request/actual, status code and indicator
 * override registers, reached from the network side and the local host.
 * Assumes both access ports and all side inputs run on CLK_SYS.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: Request field bits 3:0 code states 1,3,2,4,8; resets to Init.
// R2: Request bit 4 acknowledges the error flag in the actual register.
// R3: Request bit 5 asks for the identification value to be loaded.
// R4: Without emulation, a network write blocks further writes until host access.
// R5: Mailbox is empty after reset; network may write at once.
// R6: Access to either byte of the request word works the mailbox.
// R7: With emulation, network writes always land and copy into actual.
// R8: Without write-ack, host read clears host event bit 0; writes ignored.
// R9: With write-ack, host write clears host event bit 0; value dropped.
// R10: Actual bits 3:0 report state with the request coding; reset Init.
// R11: Actual bit 4 is the error flag, set by local action.
// R12: Actual bit 5 reports the identification value is loaded.
// R13: Host writes actual only without emulation; otherwise it mirrors requests.
// R14: Network read of actual clears network event bit 3.
// R15: Host should not read the actual register; it owns it.
// R16: Status code resets to zero; host read/write, network read only.
// R17: Run override code drives the run lamp while bit 4 enabled.
// R18: A valid change of actual state clears the run override enable.
// R19: Override reads return the code now driving the lamp.
// R20: Error override code drives the error lamp while bit 4 enabled.
// R21: A new error condition clears the error override enable.
// R22: Lamp timing comes from a local divider of the core clock.
module alr_state_regs
    import alr_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic NET_RD,
    input wire logic NET_WR,
    input wire logic [15:0] NET_ADDR,
    input wire logic [1:0] NET_BE,
    input wire logic [15:0] NET_WDATA,
    output logic [15:0] NET_RDATA,
    output logic NET_RVALID,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [15:0] HOST_ADDR,
    input wire logic [1:0] HOST_BE,
    input wire logic [15:0] HOST_WDATA,
    output logic [15:0] HOST_RDATA,
    output logic HOST_RVALID,
    input wire logic EMULATION,
    input wire logic WR_ACK_MODE,
    input wire logic ERR_NEW,
    input wire logic [3:0] ERR_AUTO_CODE,
    output logic NET_EVT_CLEAR_STATUS,
    output logic HOST_EVT_CLEAR_CONTROL,
    output logic CONTROL_PENDING,
    output logic RUN_INDICATOR,
    output logic ERROR_INDICATOR
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [5:0] ctrl;
        logic mbox_full;
        logic [5:0] stat;
        logic [15:0] code;
        logic [4:0] run_ovr;
        logic [4:0] err_ovr;
        logic [15:0] net_rdata;
        logic net_rvalid;
        logic [15:0] host_rdata;
        logic host_rvalid;
        logic net_evt_clr;
        logic host_evt_clr;
        logic run_out;
        logic err_out;
    } alr_regs_t;

    localparam alr_regs_t REGS_RESET = '{
        ctrl: STATE_REQUEST_RESET,
        mbox_full: 1'b0,
        stat: STATE_ACTUAL_RESET,
        code: STATUS_CODE_RESET,
        run_ovr: OVERRIDE_RESET,
        err_ovr: OVERRIDE_RESET,
        default: '0
    };

    alr_regs_t r;
    alr_regs_t next_r;

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [15:0] addr,
                                 input logic [1:0] be,
                                 input logic [15:0] base);
        return (addr[15:1] == base[15:1]) && (be != 2'b00);
    endfunction

    // R19 override words return the code in force
    function automatic logic [15:0] rd_mux(input logic [15:0] addr,
                                           input alr_regs_t s,
                                           input logic [3:0] run_code,
                                           input logic [3:0] err_code);
        logic [15:0] d;
        d = 16'h0000;
        if (addr[15:1] == ADDR_STATE_REQUEST[15:1]) begin
            d = {10'h000, s.ctrl};
        end else if (addr[15:1] == ADDR_STATE_ACTUAL[15:1]) begin
            d = {10'h000, s.stat};
        end else if (addr[15:1] == ADDR_STATUS_CODE[15:1]) begin
            d = s.code;
        end else if (addr[15:1] == ADDR_RUN_OVERRIDE[15:1]) begin
            d = {3'h0, s.err_ovr[BIT_OVR_EN], err_code,
                 3'h0, s.run_ovr[BIT_OVR_EN], run_code};
        end
        return d;
    endfunction

    // ---------------------------------------------------------------
    // Indicator timing and codes in force
    // ---------------------------------------------------------------
    logic tick, run_level, err_level;
    logic [3:0] run_code, err_code;
    // R17 run code in force
    assign run_code = r.run_ovr[BIT_OVR_EN] ? r.run_ovr[3:0] :
                      run_code_of_state(r.stat[3:0]);
    // R20 error code in force
    assign err_code = r.err_ovr[BIT_OVR_EN] ? r.err_ovr[3:0] :
                      ERR_AUTO_CODE;
    // R22 shared lamp divider
    alr_tick_div #(
        .DIV(TICK_DIV)
    ) u_div (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .tick(tick)
    );
    alr_ind_pattern u_run (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .tick(tick),
        .code(run_code),
        .level(run_level)
    );
    alr_ind_pattern u_err (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .tick(tick),
        .code(err_code),
        .level(err_level)
    );

    // ---------------------------------------------------------------
    // Access qualification
    // ---------------------------------------------------------------
    logic net_ctrl_wr, host_ctrl_ack, net_stat_rd, stat_change;
    logic [5:0] new_stat;
    // R4 blocked while full; R5 full clears at reset; R7 always open
    assign net_ctrl_wr = NET_WR && hit(NET_ADDR, NET_BE, ADDR_STATE_REQUEST) &&
                         (EMULATION || !r.mbox_full);
    // R6 either byte lane counts; R8 read, R9 write acknowledges
    assign host_ctrl_ack = hit(HOST_ADDR, HOST_BE, ADDR_STATE_REQUEST) &&
                           ((HOST_RD && !WR_ACK_MODE) ||
                            (HOST_WR && WR_ACK_MODE));
    assign net_stat_rd = NET_RD && hit(NET_ADDR, NET_BE, ADDR_STATE_ACTUAL);

    always_comb begin
        new_stat = r.stat;
        // R7 emulation copy; R13 host write only without emulation
        if (EMULATION) begin
            if (net_ctrl_wr && NET_BE[0]) begin
                new_stat = NET_WDATA[5:0];
            end
        end else if (HOST_WR && HOST_BE[0] &&
                     hit(HOST_ADDR, HOST_BE, ADDR_STATE_ACTUAL)) begin
            // R11 R12 error and identification flags owned by host
            new_stat = HOST_WDATA[5:0];
        end
    end

    // R18 valid state value that differs from the current one
    assign stat_change = (new_stat != r.stat) && state_valid(new_stat[3:0]);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.net_rvalid = NET_RD;
        next_r.host_rvalid = HOST_RD;
        if (NET_RD) begin
            next_r.net_rdata = rd_mux(NET_ADDR, r, run_code, err_code);
        end
        if (HOST_RD) begin
            next_r.host_rdata = rd_mux(HOST_ADDR, r, run_code, err_code);
        end
        // R1 R2 R3 request fields; upper byte is reserved
        // R8 R9 host writes never store into the request word
        if (net_ctrl_wr && NET_BE[0]) begin
            next_r.ctrl = NET_WDATA[5:0];
        end
        // R4 new write fills; set wins over a same-cycle acknowledge
        if (net_ctrl_wr && !EMULATION) begin
            next_r.mbox_full = 1'b1;
        end else if (host_ctrl_ack || EMULATION) begin
            next_r.mbox_full = 1'b0;
        end
        next_r.host_evt_clr = host_ctrl_ack;
        // R10 actual state register
        next_r.stat = new_stat;
        // R14 event clear on network read
        next_r.net_evt_clr = net_stat_rd;
        // R16 host-only writes, per byte lane
        if (HOST_WR && hit(HOST_ADDR, HOST_BE, ADDR_STATUS_CODE)) begin
            if (HOST_BE[0]) begin
                next_r.code[7:0] = HOST_WDATA[7:0];
            end
            if (HOST_BE[1]) begin
                next_r.code[15:8] = HOST_WDATA[15:8];
            end
        end
        // Both sides write overrides; the network wins a tie
        if (HOST_WR && hit(HOST_ADDR, HOST_BE, ADDR_RUN_OVERRIDE)) begin
            if (HOST_BE[0]) begin
                next_r.run_ovr = HOST_WDATA[4:0];
            end
            if (HOST_BE[1]) begin
                next_r.err_ovr = HOST_WDATA[12:8];
            end
        end
        if (NET_WR && hit(NET_ADDR, NET_BE, ADDR_RUN_OVERRIDE)) begin
            if (NET_BE[0]) begin
                next_r.run_ovr = NET_WDATA[4:0];
            end
            if (NET_BE[1]) begin
                next_r.err_ovr = NET_WDATA[12:8];
            end
        end
        // R18 state change returns run lamp to automatic
        if (stat_change) begin
            next_r.run_ovr[BIT_OVR_EN] = 1'b0;
        end
        // R21 new error returns error lamp to automatic
        if (ERR_NEW) begin
            next_r.err_ovr[BIT_OVR_EN] = 1'b0;
        end
        next_r.run_out = run_level;
        next_r.err_out = err_level;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign NET_RDATA = r.net_rdata;
    assign NET_RVALID = r.net_rvalid;
    assign HOST_RDATA = r.host_rdata;
    assign HOST_RVALID = r.host_rvalid;
    assign NET_EVT_CLEAR_STATUS = r.net_evt_clr;
    assign HOST_EVT_CLEAR_CONTROL = r.host_evt_clr;
    assign CONTROL_PENDING = r.mbox_full;
    assign RUN_INDICATOR = r.run_out;
    assign ERROR_INDICATOR = r.err_out;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    logic [5:0] net_wlow;
    logic host_ctrl_wr;
    assign net_wlow = NET_WDATA[5:0];
    assign host_ctrl_wr = HOST_WR && hit(HOST_ADDR, HOST_BE, ADDR_STATE_REQUEST);

    property p_mbox_block;
        NET_WR && hit(NET_ADDR, NET_BE, ADDR_STATE_REQUEST) && !EMULATION &&
        r.mbox_full |=> r.ctrl == $past(r.ctrl);
    endproperty
    a_mbox_block: assert property (p_mbox_block) else // R4
        $error("request written while mailbox full");
    property p_mbox_fill;
        net_ctrl_wr && !EMULATION |=> CONTROL_PENDING ##1 1'b1;
    endproperty
    a_mbox_fill: assert property (p_mbox_fill) else // R4
        $error("accepted write did not fill mailbox");
    property p_host_ack;
        HOST_RD && hit(HOST_ADDR, HOST_BE, ADDR_STATE_REQUEST) &&
        !WR_ACK_MODE && !net_ctrl_wr |=> !CONTROL_PENDING &&
        HOST_EVT_CLEAR_CONTROL;
    endproperty
    a_host_ack: assert property (p_host_ack) else // R8
        $error("host read did not acknowledge mailbox");
    property p_emul_copy;
        EMULATION && net_ctrl_wr && NET_BE[0] |=>
        r.stat == $past(net_wlow) && r.ctrl == $past(net_wlow);
    endproperty
    a_emul_copy: assert property (p_emul_copy) else // R7
        $error("emulation copy missing");
    property p_host_ctrl_ignored;
        host_ctrl_wr && !net_ctrl_wr |=> $stable(r.ctrl);
    endproperty
    a_host_ctrl_ignored: assert property (p_host_ctrl_ignored) else // R8
        $error("host write changed request");
    property p_ack_write;
        host_ctrl_wr && WR_ACK_MODE |=> HOST_EVT_CLEAR_CONTROL;
    endproperty
    a_ack_write: assert property (p_ack_write) else // R9
        $error("write acknowledge missed event clear");
    property p_stat_locked;
        EMULATION && !net_ctrl_wr |=> $stable(r.stat);
    endproperty
    a_stat_locked: assert property (p_stat_locked) else // R13
        $error("actual changed under emulation without request");
    property p_net_stat_rd;
        1'b1 |=> NET_EVT_CLEAR_STATUS == $past(net_stat_rd);
    endproperty
    a_net_stat_rd: assert property (p_net_stat_rd) else // R14
        $error("network event clear mismatch");
    property p_code_ro;
        !(HOST_WR && hit(HOST_ADDR, HOST_BE, ADDR_STATUS_CODE)) |=>
        $stable(r.code);
    endproperty
    a_code_ro: assert property (p_code_ro) else // R16
        $error("status code changed without host write");
    property p_run_clear;
        stat_change |=> !r.run_ovr[BIT_OVR_EN];
    endproperty
    a_run_clear: assert property (p_run_clear) else // R18
        $error("run override survived state change");
    property p_err_clear;
        ERR_NEW |=> !r.err_ovr[BIT_OVR_EN];
    endproperty
    a_err_clear: assert property (p_err_clear) else // R21
        $error("error override survived new error");
    property p_read_code;
        HOST_RD && hit(HOST_ADDR, HOST_BE, ADDR_RUN_OVERRIDE) |=>
        HOST_RDATA[3:0] == $past(run_code);
    endproperty
    a_read_code: assert property (p_read_code) else // R19
        $error("override read not code in force");
    property p_run_on;
        run_code == IND_ON [*3] |=> RUN_INDICATOR;
    endproperty
    a_run_on: assert property (p_run_on) else // R17
        $error("run lamp dark with code on");
    c_mbox_cycle: cover property (net_ctrl_wr && !EMULATION ##[1:20]
                                  host_ctrl_ack);
    c_emul_copy: cover property (EMULATION && net_ctrl_wr);
    c_run_cleared: cover property (r.run_ovr[BIT_OVR_EN] && stat_change);

endmodule // alr_state_regs

`default_nettype wire

// ==== alr_bus_model.sv ====
/* Bus master model for one register access port.
   Assumes one-cycle strobes, answer on the next edge. */
`timescale 1ns/1ps
`default_nettype none

module alr_bus_model (
    input wire logic clk,
    output logic rd,
    output logic wr,
    output logic [15:0] addr,
    output logic [1:0] be,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    initial begin
        {rd, wr, addr, be, wdata} = '0;
    end

    // -----------------------------------------------------------
    // One access
    // -----------------------------------------------------------
    // Released address and data invert and strobes drop low so stale values never look valid
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [1:0] b, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge clk);
        #1;
        {rd, wr, addr, be, wdata} = {~w, w, a, b, d};
        @(posedge clk);
        #1;
        {rd, wr, addr, wdata} = {2'b00, ~a, ~d};
        q = rdata;
    endtask
endmodule // alr_bus_model

`default_nettype wire

// ==== alr_state_regs_bench.sv ====
/* Self-checking bench for the state and indicator register group.
   Assumes alr_pkg and the bus model are compiled first. */
`timescale 1ns/1ps
`default_nettype none

module alr_state_regs_bench;
    import alr_pkg::*;
    logic clk_sys, rst_b, emu, wack, err_new;
    logic pend, hclr, nclr, run_ind, err_ind, net_rv, host_rv;
    logic net_rd, net_wr, host_rd, host_wr;
    logic [1:0] net_be, host_be;
    logic [3:0] err_code;
    logic [15:0] q, rnd, net_addr, net_wdata, net_rdata;
    logic [15:0] host_addr, host_wdata, host_rdata;
    logic [15:0] ra[5] = '{16'h0120, 16'h0130, 16'h0134, 16'h0138, 16'h0200};
    logic [15:0] re[5] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    int error_cnt = 0;
    int cmp_count = 0;
    int st_q[$] = '{1, 3, 2, 4, 8};
    int req_m;

    alr_state_regs #(.TICK_DIV(4)) u_alr_state_regs (
        .CLK_SYS(clk_sys), .RST_B(rst_b),
        .NET_RD(net_rd), .NET_WR(net_wr), .NET_ADDR(net_addr),
        .NET_BE(net_be), .NET_WDATA(net_wdata), .NET_RDATA(net_rdata),
        .NET_RVALID(net_rv), .HOST_RD(host_rd), .HOST_WR(host_wr),
        .HOST_ADDR(host_addr), .HOST_BE(host_be),
        .HOST_WDATA(host_wdata), .HOST_RDATA(host_rdata),
        .HOST_RVALID(host_rv), .EMULATION(emu), .WR_ACK_MODE(wack),
        .ERR_NEW(err_new), .ERR_AUTO_CODE(err_code),
        .NET_EVT_CLEAR_STATUS(nclr), .HOST_EVT_CLEAR_CONTROL(hclr),
        .CONTROL_PENDING(pend), .RUN_INDICATOR(run_ind),
        .ERROR_INDICATOR(err_ind));
    alr_bus_model u_net (.clk(clk_sys), .rd(net_rd), .wr(net_wr),
        .addr(net_addr), .be(net_be), .wdata(net_wdata),
        .rdata(net_rdata));
    alr_bus_model u_host (.clk(clk_sys), .rd(host_rd), .wr(host_wr),
        .addr(host_addr), .be(host_be), .wdata(host_wdata),
        .rdata(host_rdata));

    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic summarize;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        cmp_count++;
        if (got !== want) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic acc(input bit h, input logic w, input logic [15:0] a,
                       input logic [1:0] b, input logic [15:0] d);
        if (h) begin
            u_host.xfer(w, a, b, d, q);
        end else begin
            u_net.xfer(w, a, b, d, q);
        end
        chk(16'(h ? host_rv : net_rv), 16'(!w));
    endtask

    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (2000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        {rst_b, emu, wack, err_new, err_code} = '0;
        rnd = 16'd16284;
        repeat (8) @(posedge clk_sys);
        #1 rst_b = 1;
        foreach (ra[i]) begin
            acc(0, 0, ra[i], 2'b11, 16'h0000);
            chk(q, re[i]);
            if (i == 1) chk(16'(nclr), 16'h0001);
        end
        chk(16'({run_ind, err_ind}), 16'h0000);
        // mailbox rounds; the host never reads actual
        foreach (st_q[i]) begin
            rnd = lfsr_next(rnd);
            req_m = {rnd[5:4], st_q[i][3:0]};
            acc(0, 1, 16'h0120, 2'b11, {rnd[15:6], 6'(req_m)});
            chk(16'(pend), 16'h0001);
            acc(0, 1, 16'h0120, 2'b01, 16'h003f);
            acc(1, 0, 16'h0121, 2'b10, 16'h0000);
            chk(q, 16'(req_m));
            chk(16'(hclr), 16'h0001);
            chk(16'(pend), 16'h0000);
            acc(1, 1, 16'h0120, 2'b11, 16'h0000);
            chk(16'(hclr), 16'h0000);
        end
        wack = 1;
        acc(0, 1, 16'h0120, 2'b11, {12'h000, ST_BOOT});
        acc(1, 1, 16'h0120, 2'b11, 16'h0000);
        chk(16'(hclr), 16'h0001);
        chk(16'(pend), 16'h0000);
        acc(0, 0, 16'h0120, 2'b11, 16'h0000);
        chk(q, 16'h0003);
        {wack, emu} = 2'b01;
        acc(0, 1, 16'h0120, 2'b11, 16'h0004);
        chk(16'(pend), 16'h0000);
        acc(0, 1, 16'h0120, 2'b11, 16'h0008);
        acc(0, 0, 16'h0130, 2'b11, 16'h0000);
        chk(q, 16'h0008);
        chk(16'(nclr), 16'h0001);
        acc(1, 1, 16'h0130, 2'b11, 16'h0002);
        acc(0, 0, 16'h0130, 2'b11, 16'h0000);
        chk(q, 16'h0008);
        emu = 0;
        acc(0, 1, 16'h0138, 2'b01, 16'h001f);
        acc(0, 0, 16'h0138, 2'b11, 16'h0000);
        chk(q, 16'h001f);
        repeat (3) @(posedge clk_sys);
        #1 chk(16'(run_ind), 16'h0001);
        acc(1, 1, 16'h0130, 2'b11, 16'h0014);
        acc(0, 0, 16'h0130, 2'b11, 16'h0000);
        chk(q, 16'h0014);
        acc(0, 0, 16'h0138, 2'b11, 16'h0000);
        chk(q, 16'h0001);
        rnd = lfsr_next(rnd);
        err_code = rnd[3:0];
        acc(1, 1, 16'h0138, 2'b10, 16'h1f00);
        acc(0, 0, 16'h0138, 2'b11, 16'h0000);
        chk(q, 16'h1f01);
        chk(16'(err_ind), 16'h0001);
        err_new = 1;
        @(posedge clk_sys);
        #1 err_new = 0;
        acc(0, 0, 16'h0138, 2'b11, 16'h0000);
        chk(q, {4'h0, err_code, 8'h01});
        rnd = lfsr_next(rnd);
        acc(1, 1, 16'h0134, 2'b11, rnd);
        acc(0, 1, 16'h0134, 2'b11, ~rnd);
        acc(0, 0, 16'h0134, 2'b11, 16'h0000);
        chk(q, rnd);
        summarize();
    end
endmodule // alr_state_regs_bench

`default_nettype wire
